// ===== bench/cond_branch_compare_unit_tb.sv
/*
  self-checking bench for the conditional-branch / compare execution unit:
  flag branches (plain and delayed), slot handling, flag clears, all compare
  conditions and signed-divide initialisation, judged at the ports.
  assumes the package and the unit are compiled first; no partner model.
*/
`timescale 1ns/1ps
`default_nettype none
// one comparison: counts it, reports a mismatch at once
`define CHK(got, exp) begin \
  nTests++; \
  if ((got) !== (exp)) begin \
    errorCnt++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
  end \
end
module cond_branch_compare_unit_tb;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic        clk_sys       = 1'b0;
  logic        rst_n         = 1'b0;
  logic [15:0] instr         = 16'h0009;
  logic        instrValid    = 1'b0;
  logic [31:0] firstOperand  = 32'h0000_0000;
  logic [31:0] secondOperand = 32'h0000_0000;
  logic [31:0] registerZero  = 32'h0000_0000;
  logic        instrReady;
  logic [31:0] pc;
  logic        intAllowed;
  logic        illegalSlot;
  logic        condFlag;
  logic        clampFlag;
  logic        divisorSign;
  logic        divResultBit;
  logic [31:0] accumUpper;
  logic [31:0] accumLower;
  logic [31:0] expPc         = 32'h0000_0000;
  logic [31:0] basePc;
  int          errorCnt      = 0;
  int          nTests        = 0;

  // 10 MHz core clock
  always #50 clk_sys = ~clk_sys;

  cond_branch_compare_unit cond_branch_compare_unit_inst (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .instr         (instr),
    .instrValid    (instrValid),
    .instrReady    (instrReady),
    .firstOperand  (firstOperand),
    .secondOperand (secondOperand),
    .registerZero  (registerZero),
    .pc            (pc),
    .intAllowed    (intAllowed),
    .illegalSlot   (illegalSlot),
    .condFlag      (condFlag),
    .clampFlag     (clampFlag),
    .divisorSign   (divisorSign),
    .divResultBit  (divResultBit),
    .accumUpper    (accumUpper),
    .accumLower    (accumLower)
  );

  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic results();
    if (errorCnt == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // offer one instruction, hold it until accepted; returns 1 ns after that edge.
  // valid stays high so back-to-back offers never touch it twice in one step
  task automatic exec(input logic [15:0] op, input logic [31:0] a, input logic [31:0] b,
                      input logic [31:0] r0);
    int n;
    n = 0;
    instr = op;
    firstOperand = a;
    secondOperand = b;
    registerZero = r0;
    instrValid = 1'b1;
    while (instrReady !== 1'b1 && n < 10) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 10) begin
      errorCnt++;
      results();
    end
    @(posedge clk_sys);
    #1;
  endtask

  // one non-branching instruction: flag result and plain pc step
  task automatic cmpOne(input logic [15:0] op, input logic [31:0] a, input logic [31:0] b,
                        input logic [31:0] r0, input logic expFlag);
    exec(op, a, b, r0);
    expPc = expPc + 32'h0000_0002;
    `CHK(condFlag, expFlag)
    `CHK(pc, expPc)
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic resetState();
    `CHK({condFlag, clampFlag, divisorSign, divResultBit, illegalSlot}, 5'h00)
    `CHK({accumUpper, accumLower}, 64'h0)
    `CHK({instrReady, intAllowed}, 2'h3)
    `CHK(pc, 32'h0000_0000)
  endtask

  // every condition, with sign and lane boundaries; results alternate
  task automatic compares();
    cmpOne(cbc_pkg::OP_COMPARE_EQUAL | 16'h0120, 32'h5, 32'h5, 32'h0, 1'b1);
    cmpOne(cbc_pkg::OP_COMPARE_EQUAL | 16'h0120, 32'h5, 32'h6, 32'h0, 1'b0);
    cmpOne(cbc_pkg::OP_CMP_SGE | 16'h0340, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 32'h0, 1'b1);
    cmpOne(cbc_pkg::OP_CMP_SGE | 16'h0340, 32'h8000_0000, 32'h7FFF_FFFF, 32'h0, 1'b0);
    cmpOne(cbc_pkg::OP_CMP_SGT | 16'h0120, 32'h1, 32'hFFFF_FFFF, 32'h0, 1'b1);
    cmpOne(cbc_pkg::OP_CMP_SGT | 16'h0120, 32'h9, 32'h9, 32'h0, 1'b0);
    cmpOne(cbc_pkg::OP_CMP_UGT | 16'h0120, 32'h8000_0000, 32'h7FFF_FFFF, 32'h0, 1'b1);
    cmpOne(cbc_pkg::OP_CMP_UGT | 16'h0120, 32'h1, 32'hFFFF_FFFF, 32'h0, 1'b0);
    cmpOne(cbc_pkg::OP_CMP_UGE | 16'h0120, 32'h5, 32'h5, 32'h0, 1'b1);
    cmpOne(cbc_pkg::OP_CMP_UGE | 16'h0120, 32'h7FFF_FFFF, 32'h8000_0000, 32'h0, 1'b0);
    cmpOne(cbc_pkg::OP_CMP_POS | 16'h0500, 32'h1, 32'h0, 32'h0, 1'b1);
    cmpOne(cbc_pkg::OP_CMP_POS | 16'h0500, 32'h0, 32'h1, 32'h0, 1'b0);
    cmpOne(cbc_pkg::OP_CMP_NNEG | 16'h0500, 32'h0, 32'h0, 32'h0, 1'b1);
    cmpOne(cbc_pkg::OP_CMP_NNEG | 16'h0500, 32'h8000_0000, 32'h0, 32'h0, 1'b0);
    cmpOne(cbc_pkg::OP_CMP_BYTE | 16'h0120, 32'h4142_4344, 32'h5859_4359, 32'h0, 1'b1);
    cmpOne(cbc_pkg::OP_CMP_BYTE | 16'h0120, 32'h4142_4344, 32'h1122_3355, 32'h0, 1'b0);
    cmpOne(cbc_pkg::OP_CMP_BYTE | 16'h0120, 32'h4100_0000, 32'h41FF_FFFF, 32'h0, 1'b1);
    cmpOne(cbc_pkg::OP_COMPARE_EQUAL_IMM | 16'h0080, 32'h0, 32'h0, 32'h0000_0080, 1'b0);
    cmpOne(cbc_pkg::OP_COMPARE_EQUAL_IMM | 16'h00FF, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
  endtask

  // sign copies and their difference; a later compare leaves them alone
  task automatic divInit();
    cmpOne(cbc_pkg::OP_DIV_INIT | 16'h0120, 32'h8000_0000, 32'h0, 32'h0, 1'b1);
    `CHK({divResultBit, divisorSign}, 2'h2)
    cmpOne(cbc_pkg::OP_DIV_INIT | 16'h0120, 32'h0, 32'h8000_0000, 32'h0, 1'b1);
    `CHK({divResultBit, divisorSign}, 2'h1)
    cmpOne(cbc_pkg::OP_DIV_INIT | 16'h0120, 32'h8000_0000, 32'hFFFF_FFFF, 32'h0, 1'b0);
    `CHK({divResultBit, divisorSign}, 2'h3)
    cmpOne(cbc_pkg::OP_COMPARE_EQUAL | 16'h0120, 32'h5, 32'h5, 32'h0, 1'b1);
    `CHK({divResultBit, divisorSign}, 2'h3)
  endtask

  // clears touch only their own target; an unknown opcode just steps
  task automatic clears();
    cmpOne(cbc_pkg::OP_CLR_ACC, 32'h1, 32'h2, 32'h3, 1'b1);
    `CHK({accumUpper, accumLower}, 64'h0)
    cmpOne(cbc_pkg::OP_CLR_CLAMP, 32'h1, 32'h2, 32'h3, 1'b1);
    `CHK(clampFlag, 1'b0)
    cmpOne(16'hFFFF, 32'h1, 32'h1, 32'h1, 1'b1);
    cmpOne(cbc_pkg::OP_CLR_COND, 32'h1, 32'h2, 32'h3, 1'b0);
  endtask

  // plain flag branch, taken: target from the given displacement, then two stall cycles
  task automatic flagBranch(input logic [7:0] disp, input logic [31:0] offs);
    cmpOne(cbc_pkg::OP_COMPARE_EQUAL, 32'h7, 32'h7, 32'h0, 1'b1);
    basePc = expPc;
    exec(cbc_pkg::OP_BR_FLAG | {8'h00, disp}, 32'h0, 32'h0, 32'h0);
    instrValid = 1'b0;
    expPc = basePc + 32'h0000_0004 + offs;
    `CHK(pc, expPc)
    `CHK(instrReady, 1'b0)
    @(posedge clk_sys);
    #1;
    `CHK(instrReady, 1'b0)
    @(posedge clk_sys);
    #1;
    `CHK(instrReady, 1'b1)
  endtask

  // delayed branch, taken and not; slot rewrites the flag it tested
  task automatic delayedBranch();
    cmpOne(cbc_pkg::OP_COMPARE_EQUAL, 32'h7, 32'h7, 32'h0, 1'b1);
    basePc = expPc;
    exec(cbc_pkg::OP_BR_FLAG_DLY | 16'h0010, 32'h0, 32'h0, 32'h0);
    `CHK(pc, basePc + 32'h0000_0002)
    `CHK(intAllowed, 1'b0)
    exec(cbc_pkg::OP_COMPARE_EQUAL, 32'h5, 32'h6, 32'h0);
    `CHK(condFlag, 1'b0)
    `CHK(pc, basePc + 32'h0000_0024)
    `CHK({intAllowed, illegalSlot}, 2'h2)
    expPc = basePc + 32'h0000_0024;
    cmpOne(cbc_pkg::OP_BR_FLAG_DLY | 16'h0010, 32'h0, 32'h0, 32'h0, 1'b0);
    `CHK(intAllowed, 1'b1)
    cmpOne(cbc_pkg::OP_BR_FLAG, 32'h0, 32'h0, 32'h0, 1'b0);
    `CHK(illegalSlot, 1'b0)
    cmpOne(cbc_pkg::OP_COMPARE_EQUAL, 32'h7, 32'h7, 32'h0, 1'b1);
    basePc = expPc;
    exec(cbc_pkg::OP_BR_FLAG_DLY | 16'h0002, 32'h0, 32'h0, 32'h0);
    exec(cbc_pkg::OP_BR_FLAG, 32'h0, 32'h0, 32'h0);
    instrValid = 1'b0;
    `CHK(illegalSlot, 1'b1)
    `CHK(pc, basePc + 32'h0000_0008)
    @(posedge clk_sys);
    #1;
    `CHK(illegalSlot, 1'b0)
    expPc = pc;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    resetState();
    compares();
    divInit();
    clears();
    flagBranch(8'h80, 32'hFFFF_FF00);
    flagBranch(8'h7F, 32'h0000_00FE);
    cmpOne(cbc_pkg::OP_CLR_COND, 32'h0, 32'h0, 32'h0, 1'b0);
    cmpOne(cbc_pkg::OP_BR_FLAG | 16'h0040, 32'h0, 32'h0, 32'h0, 1'b0);
    `CHK(instrReady, 1'b1)
    delayedBranch();
    results();
  end
endmodule // cond_branch_compare_unit_tb
`default_nettype wire

// ===== rtl/cbc_compare.sv
/*
  comparison engine: all nine compare conditions and the signed-divide
  initial sign test, purely combinational.
  assumes operands are already read from the register file.
*/
`timescale 1ns/1ps
`default_nettype none
module cbc_compare (
  // operation and operands
  input  wire logic [3:0]  opCode,
  input  wire logic [31:0] firstOperand,
  input  wire logic [31:0] secondOperand,
  input  wire logic [31:0] registerZero,
  input  wire logic [7:0]  imm8,
  // result
  output logic             condResult
);
  logic [31:0] immExt;
  logic [3:0]  laneEq;

  assign immExt = {{24{imm8[7]}}, imm8}; // sign-extended immediate

  // one equality per byte lane
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign laneEq[g] = (firstOperand[8*g +: 8] == secondOperand[8*g +: 8]);
  end

  // ------------------------------------------------------------
  // condition select
  // ------------------------------------------------------------
  always_comb begin
    condResult = 1'b0;
    case (cbc_pkg::op_e'(opCode))
      cbc_pkg::OP_EQ:   condResult = (firstOperand == secondOperand);
      cbc_pkg::OP_SGE:  condResult = ($signed(firstOperand) >= $signed(secondOperand));
      cbc_pkg::OP_SGT:  condResult = ($signed(firstOperand) > $signed(secondOperand));
      cbc_pkg::OP_UGT:  condResult = (firstOperand > secondOperand);
      cbc_pkg::OP_UGE:  condResult = (firstOperand >= secondOperand);
      cbc_pkg::OP_POS:  condResult = ($signed(firstOperand) > 32'sh0);
      cbc_pkg::OP_NNEG: condResult = ~firstOperand[cbc_pkg::SIGN_BIT];
      cbc_pkg::OP_BYTE: condResult = |laneEq;
      cbc_pkg::OP_EQI:  condResult = (registerZero == immExt);
      cbc_pkg::OP_DIV0: condResult = firstOperand[cbc_pkg::SIGN_BIT] ^
                                     secondOperand[cbc_pkg::SIGN_BIT];
      default:          condResult = 1'b0;
    endcase
  end
endmodule : cbc_compare
`default_nettype wire

// ===== rtl/cbc_dec_if.sv
/*
  interface carrying the decoded operation from the decoder to the core.
  assumes both ends share clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
interface cbc_dec_if;
  logic [15:0]    instr;
  cbc_pkg::op_e   op;
  logic           isBranch;
  modport dec (input instr, output op, output isBranch);
  modport core (output instr, input op, input isBranch);
endinterface : cbc_dec_if
`default_nettype wire

// ===== rtl/cbc_decode.sv
/*
  combinational decoder for the branch / compare / flag-clear group.
  assumes a full 16-bit instruction word on the interface.
*/
`timescale 1ns/1ps
`default_nettype none
module cbc_decode (
  // decode channel
  cbc_dec_if.dec  dec
);
  // pattern test, used for every opcode row
  function automatic logic hit(input logic [15:0] w, input logic [15:0] p,
                               input logic [15:0] m);
    hit = ((w & m) == p);
  endfunction

  // ------------------------------------------------------------
  // opcode decode; exact-match rows first
  // ------------------------------------------------------------
  always_comb begin
    dec.op = cbc_pkg::OP_NONE;
    if (hit(dec.instr, cbc_pkg::OP_CLR_ACC, cbc_pkg::MASK_ALL)) dec.op = cbc_pkg::OP_CLRACC;
    else if (hit(dec.instr, cbc_pkg::OP_CLR_CLAMP, cbc_pkg::MASK_ALL)) dec.op = cbc_pkg::OP_CLEAR_CLAMP_FLAG;
    else if (hit(dec.instr, cbc_pkg::OP_CLR_COND, cbc_pkg::MASK_ALL)) dec.op = cbc_pkg::OP_CLEAR_COND_FLAG;
    else if (hit(dec.instr, cbc_pkg::OP_BR_FLAG, cbc_pkg::MASK_HI8)) dec.op = cbc_pkg::OP_BT;
    else if (hit(dec.instr, cbc_pkg::OP_BR_FLAG_DLY, cbc_pkg::MASK_HI8)) dec.op = cbc_pkg::OP_BTS;
    else if (hit(dec.instr, cbc_pkg::OP_COMPARE_EQUAL_IMM, cbc_pkg::MASK_HI8)) dec.op = cbc_pkg::OP_EQI;
    else if (hit(dec.instr, cbc_pkg::OP_COMPARE_EQUAL, cbc_pkg::MASK_RR)) dec.op = cbc_pkg::OP_EQ;
    else if (hit(dec.instr, cbc_pkg::OP_CMP_SGE, cbc_pkg::MASK_RR)) dec.op = cbc_pkg::OP_SGE;
    else if (hit(dec.instr, cbc_pkg::OP_CMP_SGT, cbc_pkg::MASK_RR)) dec.op = cbc_pkg::OP_SGT;
    else if (hit(dec.instr, cbc_pkg::OP_CMP_UGT, cbc_pkg::MASK_RR)) dec.op = cbc_pkg::OP_UGT;
    else if (hit(dec.instr, cbc_pkg::OP_CMP_UGE, cbc_pkg::MASK_RR)) dec.op = cbc_pkg::OP_UGE;
    else if (hit(dec.instr, cbc_pkg::OP_CMP_BYTE, cbc_pkg::MASK_RR)) dec.op = cbc_pkg::OP_BYTE;
    else if (hit(dec.instr, cbc_pkg::OP_DIV_INIT, cbc_pkg::MASK_RR)) dec.op = cbc_pkg::OP_DIV0;
    else if (hit(dec.instr, cbc_pkg::OP_CMP_POS, cbc_pkg::MASK_R)) dec.op = cbc_pkg::OP_POS;
    else if (hit(dec.instr, cbc_pkg::OP_CMP_NNEG, cbc_pkg::MASK_R)) dec.op = cbc_pkg::OP_NNEG;
  end

  // slot checks only see this group's two branches
  assign dec.isBranch = (dec.op == cbc_pkg::OP_BT) || (dec.op == cbc_pkg::OP_BTS);
endmodule : cbc_decode
`default_nettype wire

// ===== rtl/cbc_pkg.sv
/*
  constants shared by the conditional-branch / compare execution unit:
  opcode patterns, masks, reset values and cycle counts.
  assumes a 16-bit instruction word and 32-bit general registers.
*/
package cbc_pkg;
  // ------------------------------------------------------------
  // opcode patterns and match masks
  // ------------------------------------------------------------
  localparam logic [15:0] OP_BR_FLAG      = 16'h8900;
  localparam logic [15:0] OP_BR_FLAG_DLY  = 16'h8D00;
  localparam logic [15:0] OP_COMPARE_EQUAL_IMM   = 16'h8800;
  localparam logic [15:0] MASK_HI8        = 16'hFF00;
  localparam logic [15:0] OP_CLR_ACC      = 16'h0028;
  localparam logic [15:0] OP_CLR_CLAMP    = 16'h0048;
  localparam logic [15:0] OP_CLR_COND     = 16'h0008;
  localparam logic [15:0] MASK_ALL        = 16'hFFFF;
  localparam logic [15:0] OP_COMPARE_EQUAL       = 16'h3000;
  localparam logic [15:0] OP_CMP_UGE      = 16'h3002;
  localparam logic [15:0] OP_CMP_SGE      = 16'h3003;
  localparam logic [15:0] OP_CMP_UGT      = 16'h3006;
  localparam logic [15:0] OP_CMP_SGT      = 16'h3007;
  localparam logic [15:0] OP_CMP_BYTE     = 16'h200C;
  localparam logic [15:0] OP_DIV_INIT     = 16'h2007;
  localparam logic [15:0] MASK_RR         = 16'hF00F;
  localparam logic [15:0] OP_CMP_POS      = 16'h4015;
  localparam logic [15:0] OP_CMP_NNEG     = 16'h4011;
  localparam logic [15:0] MASK_R          = 16'hF0FF;

  // ------------------------------------------------------------
  // reset values, offsets and timing
  // ------------------------------------------------------------
  localparam logic [31:0] PC_RESET        = 32'h0000_0000;
  localparam logic [31:0] PC_STEP         = 32'h0000_0002;
  localparam logic [31:0] BASE_OFFSET     = 32'h0000_0004;
  localparam int          SIGN_BIT        = 31;
  localparam logic [1:0]  TAKEN_CYCLES    = 2'h3;
  localparam logic [1:0]  TAKEN_DLY_CYCLES = 2'h2;

  // ------------------------------------------------------------
  // operation selected by the decoder
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_BT, OP_BTS, OP_CLRACC, OP_CLEAR_CLAMP_FLAG, OP_CLEAR_COND_FLAG, OP_EQ, OP_SGE, OP_SGT,
    OP_UGT, OP_UGE, OP_POS, OP_NNEG, OP_BYTE, OP_EQI, OP_DIV0
  } op_e;
endpackage : cbc_pkg

// ===== rtl/cond_branch_compare_unit.sv
/*
  execution unit for conditional branches, compares, flag clears and
  signed-divide initialisation. one instruction is offered per cycle on
  instr with instrValid; the unit answers with instrReady.
  assumes the pipeline fetches from pc and presents register operands
  for the offered instruction in the same cycle.
*/
// What this block does
// - flag branch jumps in three cycles when set, falls through in one otherwise.
// - delayed flag branch decoded; when set, branches after the next instruction.
// - displacement is sign-extended and doubled for both conditional branches.
// - branch base is the branch address plus four.
// - taken delayed branch runs its slot instruction fully before jumping.
// - no interrupts accepted between a taken delayed branch and its slot.
// - a branch in a taken delayed slot raises illegal slot exception.
// - untaken delayed branch is a no-op; interrupts allowed, no slot check.
// - target is computed before the slot runs, so slot writes cannot alter it.
// - clear accumulator zeroes both halves in one cycle, flag untouched.
// - clear clamp flag zeroes it in one cycle, condition flag untouched.
// - clear condition flag zeroes it in one cycle.
// - compares write flag one on true, zero otherwise, one cycle, no register change.
// - signed greater-equal and greater-than treat operands as two's complement.
// - unsigned greater and greater-equal treat operands as unsigned.
// - positive and non-negative compare the first operand with zero, signed.
// - byte compare sets the flag when any matching byte lane is equal.
// - immediate equal sign-extends eight bits and compares with register zero.
// - divide init copies both sign bits and sets flag when they differ.
`timescale 1ns/1ps
`default_nettype none
module cond_branch_compare_unit (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // instruction offer
  input  wire logic [15:0] instr,
  input  wire logic        instrValid,
  output logic             instrReady,
  // register operands
  input  wire logic [31:0] firstOperand,
  input  wire logic [31:0] secondOperand,
  input  wire logic [31:0] registerZero,
  // program counter and interrupt control
  output logic [31:0]      pc,
  output logic             intAllowed,
  output logic             illegalSlot,
  // status bits and accumulator
  output logic             condFlag,
  output logic             clampFlag,
  output logic             divisorSign,
  output logic             divResultBit,
  output logic [31:0]      accumUpper,
  output logic [31:0]      accumLower
);
  // ------------------------------------------------------------
  // state and declarations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_STALL, ST_SLOT} seq_e;

  seq_e        seq_reg;
  logic [1:0]  stall_reg;
  logic [31:0] pc_reg;
  logic [31:0] target_reg;
  logic        cond_reg;
  logic        clamp_reg;
  logic        dsign_reg;
  logic        dres_reg;
  logic [31:0] accHi_reg;
  logic [31:0] accLo_reg;
  logic        illegal_reg;
  logic [31:0] target_next;
  logic        condResult;
  logic        fire;
  logic        taken;
  logic [31:0] dispExt;
  cbc_pkg::op_e op;

  cbc_dec_if decBus ();

  assign decBus.instr = instr;
  assign op           = decBus.op;

  cbc_decode u_decode (
    .dec (decBus)
  );

  cbc_compare u_compare (
    .opCode        (decBus.op),
    .firstOperand  (firstOperand),
    .secondOperand (secondOperand),
    .registerZero  (registerZero),
    .imm8          (instr[7:0]),
    .condResult    (condResult)
  );

  // ------------------------------------------------------------
  // handshake and branch target
  // ------------------------------------------------------------
  assign instrReady = (seq_reg != ST_STALL);
  assign fire       = instrValid && instrReady;
  assign taken      = cond_reg && ((op == cbc_pkg::OP_BT) || (op == cbc_pkg::OP_BTS));
  // doubled sign-extended displacement
  assign dispExt     = {{23{instr[7]}}, instr[7:0], 1'b0};
  assign target_next = pc_reg + cbc_pkg::BASE_OFFSET + dispExt;

  // interrupts blocked from a taken delayed branch until its slot retires
  assign intAllowed = (seq_reg == ST_RUN) &&
                      !(instrValid && taken && op == cbc_pkg::OP_BTS);

  assign pc           = pc_reg;
  assign illegalSlot  = illegal_reg;
  assign condFlag     = cond_reg;
  assign clampFlag    = clamp_reg;
  assign divisorSign  = dsign_reg;
  assign divResultBit = dres_reg;
  assign accumUpper   = accHi_reg;
  assign accumLower   = accLo_reg;

  // ------------------------------------------------------------
  // sequencing: stall cycles and delay slot
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg   <= ST_RUN;
      stall_reg <= 2'h0;
    end else begin
      case (seq_reg)
        ST_RUN, ST_SLOT: begin
          if (fire && taken && op == cbc_pkg::OP_BT) begin
            seq_reg   <= ST_STALL;
            stall_reg <= cbc_pkg::TAKEN_CYCLES - 2'h1;
          end else if (fire && taken && op == cbc_pkg::OP_BTS && seq_reg == ST_RUN) begin
            seq_reg <= ST_SLOT;
          end else if (fire) begin
            seq_reg <= ST_RUN;
          end
        end
        ST_STALL: begin
          stall_reg <= stall_reg - 2'h1;
          if (stall_reg == 2'h1) begin
            seq_reg <= ST_RUN;
          end
        end
        default: seq_reg <= ST_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------
  // program counter; target latched before the slot runs
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg     <= cbc_pkg::PC_RESET;
      target_reg <= cbc_pkg::PC_RESET;
    end else if (fire) begin
      if (seq_reg == ST_SLOT) begin
        pc_reg <= target_reg;
      end else if (taken && op == cbc_pkg::OP_BTS) begin
        target_reg <= target_next;
        pc_reg     <= pc_reg + cbc_pkg::PC_STEP;
      end else if (taken) begin
        pc_reg <= target_next;
      end else begin
        pc_reg <= pc_reg + cbc_pkg::PC_STEP;
      end
    end
  end

  // ------------------------------------------------------------
  // illegal slot detection; pulses one cycle
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      illegal_reg <= 1'b0;
    end else begin
      illegal_reg <= fire && (seq_reg == ST_SLOT) && decBus.isBranch;
    end
  end

  // ------------------------------------------------------------
  // condition flag: compares, divide init, clear
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cond_reg <= 1'b0;
    end else if (fire && !(seq_reg == ST_SLOT && decBus.isBranch)) begin
      case (op)
        cbc_pkg::OP_CLEAR_COND_FLAG: cond_reg <= 1'b0;
        cbc_pkg::OP_EQ, cbc_pkg::OP_SGE, cbc_pkg::OP_SGT, cbc_pkg::OP_UGT,
        cbc_pkg::OP_UGE, cbc_pkg::OP_POS, cbc_pkg::OP_NNEG, cbc_pkg::OP_BYTE,
        cbc_pkg::OP_EQI, cbc_pkg::OP_DIV0: cond_reg <= condResult;
        default: cond_reg <= cond_reg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // clamp and divide sign bits
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clamp_reg <= 1'b0;
      dsign_reg <= 1'b0;
      dres_reg  <= 1'b0;
    end else if (fire) begin
      if (op == cbc_pkg::OP_CLEAR_CLAMP_FLAG) begin
        clamp_reg <= 1'b0;
      end
      if (op == cbc_pkg::OP_DIV0) begin
        dres_reg  <= firstOperand[cbc_pkg::SIGN_BIT];
        dsign_reg <= secondOperand[cbc_pkg::SIGN_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // accumulator pair
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      accHi_reg <= 32'h0000_0000;
      accLo_reg <= 32'h0000_0000;
    end else if (fire && op == cbc_pkg::OP_CLRACC) begin
      accHi_reg <= 32'h0000_0000;
      accLo_reg <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_BT_TAKEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && taken && op == cbc_pkg::OP_BT && seq_reg == ST_RUN) |=> !instrReady [*2] ##1 instrReady)
    else $error("taken branch did not stall two cycles");
  AST_BT_TARGET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && taken && seq_reg == ST_RUN && op == cbc_pkg::OP_BT) |=>
      pc == $past(pc) + 32'h0000_0004 + {{23{$past(instr[7])}}, $past(instr[7:0]), 1'b0})
    else $error("branch target wrong");
  AST_BTS_SLOT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && taken && op == cbc_pkg::OP_BTS && seq_reg == ST_RUN) |=>
      pc == $past(pc) + 32'h0000_0002)
    else $error("slot not fetched before jump");
  AST_NO_INT_SLOT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (seq_reg == ST_SLOT) |-> !intAllowed)
    else $error("interrupt allowed in delay slot");
  AST_ILLEGAL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && seq_reg == ST_SLOT && decBus.isBranch) |=> illegalSlot)
    else $error("branch in slot not flagged");
  AST_STEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && seq_reg == ST_RUN && !taken) |=> pc == $past(pc) + 32'h0000_0002)
    else $error("pc did not advance by two");
  AST_CLRACC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && op == cbc_pkg::OP_CLRACC) |=> accumUpper == 32'h0 && accumLower == 32'h0 &&
      $stable(condFlag))
    else $error("accumulator not cleared");
  AST_CMP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && seq_reg == ST_RUN && op == cbc_pkg::OP_UGE) |=>
      condFlag == ($past(firstOperand) >= $past(secondOperand)))
    else $error("compare result wrong");
  AST_DIV0: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && op == cbc_pkg::OP_DIV0) |=> divResultBit == $past(firstOperand[31]) &&
      divisorSign == $past(secondOperand[31]))
    else $error("divide init signs wrong");
  AST_CLEAR_COND_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && op == cbc_pkg::OP_CLEAR_COND_FLAG) |=> !condFlag)
    else $error("condition flag not cleared");
  AST_CLEAR_CLAMP_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && op == cbc_pkg::OP_CLEAR_CLAMP_FLAG) |=> !clampFlag && $stable(condFlag))
    else $error("clamp flag not cleared");
  AST_SLOT_PC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && seq_reg == ST_SLOT) |=> pc == $past(target_reg))
    else $error("slot did not jump to latched target");
  AST_BTS_NT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (seq_reg == ST_RUN && op == cbc_pkg::OP_BTS && !cond_reg) |-> intAllowed)
    else $error("untaken delayed branch blocked interrupts");
  AST_SGT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && op == cbc_pkg::OP_SGT) |=>
      condFlag == ($signed($past(firstOperand)) > $signed($past(secondOperand))))
    else $error("signed compare wrong");
  AST_EQI: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && op == cbc_pkg::OP_EQI) |=>
      condFlag == ($past(registerZero) == {{24{$past(instr[7])}}, $past(instr[7:0])}))
    else $error("immediate compare wrong");
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !fire |=> $stable({condFlag, clampFlag, divisorSign, divResultBit}))
    else $error("status bit changed with no instruction");
endmodule : cond_branch_compare_unit
`default_nettype wire
